// *** dcp_pkg.sv ***
// Shared constants, types and parity functions for the data cache parity block
package dcp_pkg;

	// ------------------------------------------------------------------
	// Address split of a 36-bit real address, 32-byte lines, 8 sets
	// ------------------------------------------------------------------
	localparam int RA_W = 36;
	localparam int TAG_W = 28;
	localparam int SET_W = 3;
	localparam int WORD_W = 3;
	localparam int TAG_LSB = 8;
	localparam int SET_LSB = 5;
	localparam int WORD_LSB = 2;
	localparam int LINE_OFS_W = 5;

	// ------------------------------------------------------------------
	// Line storage layout of the RAM part of a line
	// ------------------------------------------------------------------
	localparam int DATA_W = 256;
	localparam int DATA_LSB = 0;
	localparam int DIRTY_LSB = 256;
	localparam int USER_LSB = 260;
	localparam int DATA_PARITY_CHECK_LSB = 264;
	localparam int TAG_PARITY_LSB = 296;
	localparam int USER_BITS_PARITY_BIT = 298;
	localparam int DIRTY_PARITY_LSB = 299;
	localparam int LINE_W = 303;
	localparam int PAR_BITS = 39;

	// ------------------------------------------------------------------
	// Debug tag register fields (vector index, bit 0 of the register = 31)
	// ------------------------------------------------------------------
	localparam int DTH_TRA_LSB = 8;
	localparam int DTH_VALID_BIT = 7;
	localparam int DTH_TAG_EXT_REAL_ADDR_LSB = 0;
	localparam int DTL_USER_BITS_PARITY_BIT = 18;
	localparam int DTL_TAG_PARITY_LSB = 16;
	localparam int DTL_DATA_PARITY_CHECK_LSB = 12;
	localparam int DTL_DIRTY_PARITY_LSB = 8;
	localparam int DTL_DIRTY_LSB = 4;
	localparam int DTL_USER_LSB = 0;
	localparam logic [31:0] DBG_RESET = 32'h0000_0000;

	// ------------------------------------------------------------------
	// Machine check status bits
	// ------------------------------------------------------------------
	localparam int MCS_SUMMARY = 0;
	localparam int MCS_SEARCH = 1;
	localparam int MCS_FLUSH = 2;

	// ------------------------------------------------------------------
	// Operation codes
	// ------------------------------------------------------------------
	typedef enum logic [3:0] {
		OP_LOAD = 4'h0,
		OP_STORE = 4'h1,
		OP_FLUSH = 4'h2,
		OP_INVAL = 4'h3,
		OP_STBACK = 4'h4,
		OP_TOUCH = 4'h5,
		OP_ZERO = 4'h6,
		OP_FILL = 4'h7,
		OP_CASTOUT = 4'h8,
		OP_DREAD = 4'h9
	} dcp_op_t;

	// Even parity over alternating tag bits, valid bit excluded
	function automatic logic [1:0] dcp_tag_par(input logic [TAG_W-1:0] t);
		dcp_tag_par = {^(t & 28'hAAAAAAA), ^(t & 28'h5555555)};
	endfunction

	// Even parity of every data byte
	function automatic logic [31:0] dcp_byte_par(input logic [255:0] d);
		logic [31:0] p;
		p = 32'h0000_0000;
		for (int i = 0; i < 32; i++) begin
			p[i] = ^d[i*8 +: 8];
		end
		dcp_byte_par = p;
	endfunction

endpackage

// *** dcp_line_ram.sv ***
// Line RAM with bit-masked write and registered read data
`timescale 1ns/1ps
module dcp_line_ram #(
	parameter int WIDTH = 303,
	parameter int DEPTH = 32,
	parameter int AW = 5
) (
	// Clock and reset
	input wire logic clock,
	input wire logic arst_n,
	input wire logic ce,
	// Write port
	input wire logic wrEn,
	input wire logic [AW-1:0] wrAddr,
	input wire logic [WIDTH-1:0] wrMask,
	input wire logic [WIDTH-1:0] wrData,
	// Read port
	input wire logic rdEn,
	input wire logic [AW-1:0] rdAddr,
	output logic [WIDTH-1:0] rdData
);

	logic [WIDTH-1:0] mem [DEPTH];
	wire [WIDTH-1:0] merged = (mem[wrAddr] & ~wrMask) | (wrData & wrMask);

	// Masked write keeps untouched fields of the line
	always_ff @(posedge clock) begin
		if (ce && wrEn) begin
			mem[wrAddr] <= merged;
		end
	end

	// Read sees the line as it stood before a same-cycle write
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			rdData <= '0;
		end else if (ce && rdEn) begin
			rdData <= mem[rdAddr];
		end
	end

endmodule

// *** dcp_dcache_debug_parity.sv ***
// Data cache line store, debug tag read, parity and multi-hit checking
`timescale 1ns/1ps
// How it works
// - Debug read is accepted only when privileged; otherwise refused, no data.
// - High debug tag: real address 0:23, valid at 24, upper four at 28:31.
// - Low debug tag: dirty flags at 24:27, user attribute bits at 28:31.
// - Parity readout enable loads parity fields 13..23; else they read zero.
// - Data parity field shows check results of the read word's bytes.
// - Line holds tag in CAM; data, dirty, user, 39 parity bits in RAM.
// - Lookups compare stored real tag against the translated real address.
// - RAM lines read by load, flush, store-back, invalidate or cast-out check stored parity.
// - Cast-out line with parity error still goes out, error flag raised.
// - Multi-hit is detected on every CAM lookup operation.
// - Debug read never raises a parity error.
// - Error with checks enabled takes machine check, saves address, state.
// - Recovery stall holds a load one cycle in last stage when needed.
// - No extra hold when the load already stalls for another reason.
// - Machine check is taken as soon as the error is seen.
// - Exactly one of search or flush status set, plus summary.
// - Search status: multi-hit, load tag/data, line-op tag errors.
// - Flush status: flush/store-back data/dirty/user, any cast-out error.
// - Parity per byte, two tag bits alternating, user, per dirty bit.
module dcp_dcache_debug_parity #(
	parameter int WAYS = 4
) (
	// Clock and reset
	input wire logic clock,
	input wire logic arst_n,
	input wire logic ce,
	// Operation request
	input wire logic opValid,
	input wire dcp_pkg::dcp_op_t opCode,
	input wire logic [35:0] opRealAddr,
	input wire logic [$clog2(WAYS)-1:0] opWay,
	input wire logic opPrivileged,
	input wire logic [31:0] opStoreData,
	input wire logic [3:0] opByteEn,
	input wire logic [255:0] fillData,
	input wire logic [3:0] fillUser,
	// Configuration and machine state
	input wire logic parityReadoutEnable,
	input wire logic parityRecoveryStallEnable,
	input wire logic machineCheckEnable,
	input wire logic [31:0] oldestAddress,
	input wire logic [31:0] machineState,
	input wire logic mcStatusClear,
	// Load pipeline last stage
	input wire logic loadInLastStage,
	input wire logic lastStageBusy,
	output logic loadHold,
	// Load and debug results
	output logic loadDone,
	output logic loadHit,
	output logic [31:0] loadData,
	output logic dbgFault,
	output logic dbgDone,
	output logic [31:0] dbgWord,
	output logic [31:0] debugTagHigh,
	output logic [31:0] debugTagLow,
	// System bus write
	output logic busWrValid,
	output logic [35:0] busWrAddr,
	output logic [255:0] busWrData,
	output logic busWrParityErr,
	// Machine check
	output logic mcTake,
	output logic [31:0] mcSavedAddress,
	output logic [31:0] mcSavedState,
	output logic [2:0] mcStatus
);

	localparam int WAY_W = $clog2(WAYS);
	localparam int IDX_W = dcp_pkg::SET_W + WAY_W;
	localparam int LINES = WAYS << dcp_pkg::SET_W;

	// ------------------------------------------------------------------
	// Request decode and CAM lookup
	// ------------------------------------------------------------------
	logic [dcp_pkg::TAG_W-1:0] camTag [LINES];
	logic [LINES-1:0] camVld;
	logic [WAYS-1:0] matchVec;
	logic [WAY_W-1:0] hitWay;

	wire [dcp_pkg::SET_W-1:0] opSet = opRealAddr[7:5];
	wire [dcp_pkg::WORD_W-1:0] opWord = opRealAddr[4:2];
	wire [dcp_pkg::TAG_W-1:0] opTag = opRealAddr[35:8];
	wire refuse = ce && opValid && opCode == dcp_pkg::OP_DREAD
		&& !opPrivileged;
	wire accept = ce && opValid && !refuse;
	wire isLookup = opCode inside {dcp_pkg::OP_LOAD, dcp_pkg::OP_STORE,
		dcp_pkg::OP_FLUSH, dcp_pkg::OP_INVAL, dcp_pkg::OP_STBACK,
		dcp_pkg::OP_TOUCH, dcp_pkg::OP_ZERO};
	wire hitAny = isLookup && (|matchVec);
	wire multiHit = isLookup && ((matchVec & (matchVec - 1'b1)) != '0);
	wire [WAY_W-1:0] useWay = hitAny ? hitWay : opWay;
	wire [IDX_W-1:0] lineIdx = {opSet, useWay};

	// Real tag compare across all ways of the set
	always_comb begin
		matchVec = '0;
		hitWay = '0;
		for (int w = WAYS - 1; w >= 0; w--) begin
			matchVec[w] = camVld[{opSet, WAY_W'(w)}]
				&& camTag[{opSet, WAY_W'(w)}] == opTag;
			if (matchVec[w]) begin
				hitWay = WAY_W'(w);
			end
		end
	end

	// ------------------------------------------------------------------
	// Line writes: fill, store, zero, store-back
	// ------------------------------------------------------------------
	logic wrEn;
	logic [dcp_pkg::LINE_W-1:0] wrMask;
	logic [dcp_pkg::LINE_W-1:0] wrData;
	logic [dcp_pkg::LINE_W-1:0] ramRd;

	wire [1:0] opTagPar = dcp_pkg::dcp_tag_par(opTag);
	wire [31:0] fillPar = dcp_pkg::dcp_byte_par(fillData);
	wire fillUpar = ^fillUser;
	wire newLine = opCode == dcp_pkg::OP_FILL
		|| (opCode == dcp_pkg::OP_ZERO && !hitAny);

	// Build mask and data; parity is computed as the line is written
	always_comb begin
		wrEn = 1'b0;
		wrMask = '0;
		wrData = '0;
		if (accept && newLine) begin
			wrEn = 1'b1;
			wrMask = '1;
			wrData[dcp_pkg::TAG_PARITY_LSB +: 2] = opTagPar;
			wrData[dcp_pkg::USER_LSB +: 4] = fillUser;
			wrData[dcp_pkg::USER_BITS_PARITY_BIT] = fillUpar;
			if (opCode == dcp_pkg::OP_FILL) begin
				wrData[dcp_pkg::DATA_LSB +: 256] = fillData;
				wrData[dcp_pkg::DATA_PARITY_CHECK_LSB +: 32] = fillPar;
			end else begin
				wrData[dcp_pkg::DIRTY_LSB +: 4] = 4'hF;
				wrData[dcp_pkg::DIRTY_PARITY_LSB +: 4] = 4'hF;
			end
		end else if (accept && hitAny && opCode == dcp_pkg::OP_ZERO) begin
			wrEn = 1'b1;
			wrMask[dcp_pkg::DATA_LSB +: 256] = '1;
			wrMask[dcp_pkg::DATA_PARITY_CHECK_LSB +: 32] = '1;
			wrMask[dcp_pkg::DIRTY_LSB +: 4] = 4'hF;
			wrMask[dcp_pkg::DIRTY_PARITY_LSB +: 4] = 4'hF;
			wrData[dcp_pkg::DIRTY_LSB +: 4] = 4'hF;
			wrData[dcp_pkg::DIRTY_PARITY_LSB +: 4] = 4'hF;
		end else if (accept && hitAny && opCode == dcp_pkg::OP_STORE) begin
			wrEn = 1'b1;
			for (int b = 0; b < 4; b++) begin
				if (opByteEn[b]) begin
					wrMask[int'(opWord)*32 + b*8 +: 8] = 8'hFF;
					wrData[int'(opWord)*32 + b*8 +: 8] = opStoreData[b*8 +: 8];
					wrMask[dcp_pkg::DATA_PARITY_CHECK_LSB + int'(opWord)*4 + b] = 1'b1;
					wrData[dcp_pkg::DATA_PARITY_CHECK_LSB + int'(opWord)*4 + b] =
						^opStoreData[b*8 +: 8];
				end
			end
			wrMask[dcp_pkg::DIRTY_LSB + int'(opWord[2:1])] = 1'b1;
			wrData[dcp_pkg::DIRTY_LSB + int'(opWord[2:1])] = 1'b1;
			wrMask[dcp_pkg::DIRTY_PARITY_LSB + int'(opWord[2:1])] = 1'b1;
			wrData[dcp_pkg::DIRTY_PARITY_LSB + int'(opWord[2:1])] = 1'b1;
		end else if (accept && hitAny && opCode == dcp_pkg::OP_STBACK) begin
			wrEn = 1'b1;
			wrMask[dcp_pkg::DIRTY_LSB +: 4] = 4'hF;
			wrMask[dcp_pkg::DIRTY_PARITY_LSB +: 4] = 4'hF;
		end
	end

	// RAM part of every line
	dcp_line_ram #(
		.WIDTH(dcp_pkg::LINE_W),
		.DEPTH(LINES),
		.AW(IDX_W)
	) u_ram (
		.clock(clock),
		.arst_n(arst_n),
		.ce(ce),
		.wrEn(wrEn),
		.wrAddr(lineIdx),
		.wrMask(wrMask),
		.wrData(wrData),
		.rdEn(accept),
		.rdAddr(lineIdx),
		.rdData(ramRd)
	);

	// CAM tag cells: written on a new line, cleared by flush/invalidate
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			camVld <= '0;
		end else if (accept && newLine) begin
			camVld[lineIdx] <= 1'b1;
		end else if (accept && hitAny && (opCode == dcp_pkg::OP_FLUSH
				|| opCode == dcp_pkg::OP_INVAL)) begin
			camVld[lineIdx] <= 1'b0;
		end
	end

	// Tag value of a newly established line
	always_ff @(posedge clock) begin
		if (accept && newLine) begin
			camTag[lineIdx] <= opTag;
		end
	end

	// ------------------------------------------------------------------
	// Stage 1: line read back, parity checks
	// ------------------------------------------------------------------
	logic s1Valid;
	dcp_pkg::dcp_op_t s1Op;
	logic s1Hit;
	logic s1Mhit;
	logic s1LineVld;
	logic s1Crpe;
	logic [dcp_pkg::TAG_W-1:0] s1Tag;
	logic [dcp_pkg::SET_W-1:0] s1Set;
	logic [dcp_pkg::WORD_W-1:0] s1Word;

	// Capture the request alongside the RAM read
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			s1Valid <= 1'b0;
			s1Op <= dcp_pkg::OP_LOAD;
			{s1Hit, s1Mhit, s1LineVld, s1Crpe} <= 4'h0;
			{s1Tag, s1Set, s1Word} <= '0;
		end else if (ce) begin
			s1Valid <= accept;
			s1Op <= opCode;
			{s1Hit, s1Mhit} <= {hitAny, multiHit};
			s1LineVld <= camVld[lineIdx];
			s1Crpe <= parityReadoutEnable;
			{s1Tag, s1Set, s1Word} <= {camTag[lineIdx], opSet, opWord};
		end
	end

	wire isLoad = s1Op == dcp_pkg::OP_LOAD;
	wire isFlushLike = s1Op == dcp_pkg::OP_FLUSH || s1Op == dcp_pkg::OP_STBACK;
	wire isInval = s1Op == dcp_pkg::OP_INVAL;
	wire isCast = s1Op == dcp_pkg::OP_CASTOUT;
	wire isDread = s1Op == dcp_pkg::OP_DREAD;
	wire [3:0] rdDirty = ramRd[dcp_pkg::DIRTY_LSB +: 4];
	wire [3:0] rdUser = ramRd[dcp_pkg::USER_LSB +: 4];
	wire [3:0] rdMpar = ramRd[dcp_pkg::DIRTY_PARITY_LSB +: 4];
	wire [31:0] dataChk = dcp_pkg::dcp_byte_par(ramRd[255:0])
		^ ramRd[dcp_pkg::DATA_PARITY_CHECK_LSB +: 32];
	wire [3:0] wordChk = dataChk[int'(s1Word)*4 +: 4];
	wire [1:0] tagChk = dcp_pkg::dcp_tag_par(s1Tag)
		^ ramRd[dcp_pkg::TAG_PARITY_LSB +: 2];
	wire userErr = (^rdUser) ^ ramRd[dcp_pkg::USER_BITS_PARITY_BIT];
	wire dirtyErr = |(rdDirty ^ ramRd[dcp_pkg::DIRTY_PARITY_LSB +: 4]);
	wire tagErr = |tagChk;
	wire dataErr = |dataChk;
	wire [31:0] rdWord = ramRd[int'(s1Word)*32 +: 32];
	// Lines actually read out of RAM for a check
	wire s1Checked = s1Valid && !isDread && (isCast ? s1LineVld
		: s1Hit && (isLoad || isFlushLike || isInval));
	wire searchEv = s1Valid && !isDread && (s1Mhit || s1Checked
		&& (isLoad && (tagErr || (|wordChk))
		|| (isFlushLike || isInval) && tagErr));
	wire flushEv = s1Checked && (isFlushLike && (dataErr || dirtyErr
		|| userErr) || isCast && (tagErr || dataErr || dirtyErr
		|| userErr));
	wire mcEvent = searchEv || flushEv;
	wire wbNeed = s1Valid && (isCast && s1LineVld
		|| isFlushLike && s1Hit && (|rdDirty));
	wire [31:0] parMask = s1Crpe ? 32'hFFFF_FFFF : 32'h0000_0000;

	// Debug tag register images
	logic [31:0] next_debugTagHigh;
	logic [31:0] next_debugTagLow;
	always_comb begin
		next_debugTagHigh = dcp_pkg::DBG_RESET;
		next_debugTagHigh[dcp_pkg::DTH_TRA_LSB +: 24] = s1Tag[23:0];
		next_debugTagHigh[dcp_pkg::DTH_VALID_BIT] = s1LineVld;
		next_debugTagHigh[dcp_pkg::DTH_TAG_EXT_REAL_ADDR_LSB +: 4] = s1Tag[27:24];
		next_debugTagLow = dcp_pkg::DBG_RESET;
		// Doubleword 0 sits in the leftmost bit, as U0 does
		next_debugTagLow[dcp_pkg::DTL_DIRTY_LSB +: 4] =
			{rdDirty[0], rdDirty[1], rdDirty[2], rdDirty[3]};
		next_debugTagLow[dcp_pkg::DTL_USER_LSB +: 4] = rdUser;
		next_debugTagLow[dcp_pkg::DTL_USER_BITS_PARITY_BIT] =
			ramRd[dcp_pkg::USER_BITS_PARITY_BIT] & parMask[0];
		next_debugTagLow[dcp_pkg::DTL_TAG_PARITY_LSB +: 2] =
			ramRd[dcp_pkg::TAG_PARITY_LSB +: 2] & parMask[1:0];
		next_debugTagLow[dcp_pkg::DTL_DATA_PARITY_CHECK_LSB +: 4] =
			wordChk & parMask[3:0];
		next_debugTagLow[dcp_pkg::DTL_DIRTY_PARITY_LSB +: 4] =
			{rdMpar[0], rdMpar[1], rdMpar[2], rdMpar[3]}
			& parMask[3:0];
	end

	// ------------------------------------------------------------------
	// Stage 2: registered results
	// ------------------------------------------------------------------
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			{loadDone, loadHit, loadData} <= '0;
			{dbgFault, dbgDone, dbgWord} <= '0;
			debugTagHigh <= dcp_pkg::DBG_RESET;
			debugTagLow <= dcp_pkg::DBG_RESET;
		end else if (ce) begin
			dbgFault <= refuse;
			loadDone <= s1Valid && isLoad;
			loadHit <= s1Hit;
			loadData <= rdWord;
			dbgDone <= s1Valid && isDread;
			if (s1Valid && isDread) begin
				dbgWord <= rdWord;
				debugTagHigh <= next_debugTagHigh;
				debugTagLow <= next_debugTagLow;
			end
		end
	end

	// Cast-out goes to the bus even when its parity is bad
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			{busWrValid, busWrParityErr, busWrAddr, busWrData} <= '0;
		end else if (ce) begin
			busWrValid <= wbNeed;
			busWrParityErr <= wbNeed && (tagErr || dataErr || dirtyErr
				|| userErr);
			busWrAddr <= {s1Tag, s1Set, 5'h00};
			busWrData <= ramRd[255:0];
		end
	end

	// Machine check entry as soon as the error shows; set beats clear
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			{mcTake, mcSavedAddress, mcSavedState} <= '0;
			mcStatus <= 3'h0;
		end else if (ce) begin
			mcTake <= mcEvent && machineCheckEnable;
			if (mcEvent && machineCheckEnable) begin
				mcSavedAddress <= oldestAddress;
				mcSavedState <= machineState;
			end
			if (mcEvent) begin
				mcStatus[dcp_pkg::MCS_SUMMARY] <= 1'b1;
				// Kind bits name only the newest error, so one stays set
				mcStatus[dcp_pkg::MCS_SEARCH] <= searchEv;
				mcStatus[dcp_pkg::MCS_FLUSH] <= !searchEv;
			end else if (mcStatusClear) begin
				mcStatus <= 3'h0;
			end
		end
	end

	// ------------------------------------------------------------------
	// Recovery stall of loads in the last stage
	// ------------------------------------------------------------------
	logic holdDone;
	assign loadHold = ce && parityRecoveryStallEnable && loadInLastStage
		&& !lastStageBusy && !holdDone && s1Valid && isLoad;

	// One hold per load; rearmed when the stage empties
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			holdDone <= 1'b0;
		end else if (ce) begin
			holdDone <= loadInLastStage && (holdDone || loadHold);
		end
	end

	// ------------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------------
	default clocking @(posedge clock); endclocking
	default disable iff (!arst_n);

	AST_DREAD_NO_MC: assert property (ce && s1Valid && isDread |=> !mcTake)
		else $error("debug read raised a machine check");
	AST_ONE_STATUS: assert property (ce && mcEvent |=>
		mcStatus[dcp_pkg::MCS_SUMMARY] && (mcStatus[dcp_pkg::MCS_SEARCH]
		!= mcStatus[dcp_pkg::MCS_FLUSH]))
		else $error("status bits not exactly one plus summary");
	AST_PAR_ZERO: assert property (ce && s1Valid && isDread && !s1Crpe
		|=> debugTagLow[18:8] == 11'h000)
		else $error("parity fields not zero with readout disabled");
	AST_RESERVED: assert property (dbgDone |->
		debugTagHigh[6:4] == 3'h0 && debugTagLow[31:19] == 13'h0000)
		else $error("reserved debug bits nonzero");
	AST_CASTOUT: assert property (accept && opCode == dcp_pkg::OP_CASTOUT
		&& camVld[lineIdx] ##1 ce |=> busWrValid)
		else $error("valid cast-out not written to bus");
	AST_MC_SAVE: assert property (ce && mcEvent && machineCheckEnable
		|=> mcTake && mcSavedAddress == $past(oldestAddress))
		else $error("machine check not taken or address not saved");
	AST_HOLD_ONE: assert property (loadHold |=> !loadHold)
		else $error("load held more than one cycle");
	AST_NO_EXTRA: assert property (lastStageBusy |-> !loadHold)
		else $error("extra hold added to a stalled load");
	AST_MULTI_HIT: assert property (accept && multiHit ##1 ce
		|=> mcStatus[dcp_pkg::MCS_SEARCH])
		else $error("multi-hit did not set search status");

	COV_DREAD: cover property (dbgDone && debugTagLow[15:12] != 4'h0);
	COV_BAD_CAST: cover property (busWrValid && busWrParityErr);
	COV_MC: cover property (mcTake);
	COV_HOLD: cover property (loadHold);

endmodule

// *** dcp_core_model.sv ***
// Load pipeline last stage and system bus sink facing the cache block
`timescale 1ns/1ps
module dcp_core_model (
	// Clock and reset
	input wire logic clock,
	input wire logic arst_n,
	// Load pipeline
	input wire logic loadIssued,
	input wire logic otherStall,
	input wire logic loadDone,
	output logic loadInLastStage,
	output logic lastStageBusy,
	// System bus write sink
	input wire logic busWrValid,
	input wire logic [35:0] busWrAddr,
	input wire logic [255:0] busWrData,
	input wire logic busWrParityErr,
	output logic [7:0] wrCount,
	output logic [35:0] wrAddr,
	output logic [31:0] wrWord,
	output logic wrErr
);
	// A load sits in the last stage from issue until its result
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) loadInLastStage <= 1'h0;
		else if (loadIssued) loadInLastStage <= 1'h1;
		else if (loadDone) loadInLastStage <= 1'h0;
	end
	// Unrelated stall only while a load is held there
	assign lastStageBusy = otherStall & loadInLastStage;
	// Every write is taken at once; the last one is kept
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			{wrCount, wrAddr, wrWord, wrErr} <= '0;
		end else if (busWrValid) begin
			wrCount <= wrCount + 8'h01;
			wrAddr <= busWrAddr;
			wrWord <= busWrData[31:0];
			wrErr <= busWrParityErr;
		end
	end
endmodule

// *** testbench.sv ***
// Self-checking bench for the data cache debug read and parity block
`timescale 1ns/1ps
module testbench;
	typedef struct packed {
		logic [35:0] a;
		logic [1:0] w;
		logic [3:0] u;
		logic p;
		logic [31:0] h;
	} dcp_row_t;
	localparam logic [31:0] OLDEST = 32'h0000_4A10;
	localparam logic [31:0] STATE = 32'h0002_1000;
	logic clock, arst_n, opValid, opPrivileged, pre, stallEn, mcEn, mcClear;
	logic otherStall, inLast, busy, loadHold, loadDone, loadHit;
	logic dbgFault, dbgDone, busWrValid, busWrParityErr, mcTake, wrErr;
	logic sawLoad, sawDbg, sawFault, sawMc, sawHold;
	dcp_pkg::dcp_op_t opCode;
	logic [35:0] opRealAddr, busWrAddr, wrAddr;
	logic [1:0] opWay;
	logic [31:0] storeData, loadData, dbgWord, tagHigh, tagLow, mcAddr;
	logic [31:0] mcState, wrWord;
	logic [3:0] byteEn, fillUser;
	logic [255:0] fillData, busWrData;
	logic [2:0] mcStatus;
	logic [7:0] wrCount;
	logic ce = 1'h1;
	wire loadIssued = opValid & (opCode == dcp_pkg::OP_LOAD);
	int bad_count = 0;
	int samples_checked = 0;
	int cycles = 0;
	dcp_row_t rows [4] = '{
		'{36'h9_1234_5674, 2'h0, 4'hA, 1'h1, 32'h1234_5689},
		'{36'h0_FEDC_BA80, 2'h3, 4'h3, 1'h0, 32'hFEDC_BA80},
		'{36'hF_0000_00FC, 2'h2, 4'h8, 1'h1, 32'h0000_008F},
		'{36'h5_AAAA_AA28, 2'h1, 4'h0, 1'h1, 32'hAAAA_AA85}};
	dcp_pkg::dcp_op_t lookOps [3] = '{dcp_pkg::OP_STORE,
		dcp_pkg::OP_TOUCH, dcp_pkg::OP_ZERO};

	dcp_dcache_debug_parity dut (.clock(clock), .arst_n(arst_n), .ce(ce),
		.opValid(opValid), .opCode(opCode), .opRealAddr(opRealAddr),
		.opWay(opWay), .opPrivileged(opPrivileged), .opStoreData(storeData),
		.opByteEn(byteEn), .fillData(fillData), .fillUser(fillUser),
		.parityReadoutEnable(pre), .parityRecoveryStallEnable(stallEn),
		.machineCheckEnable(mcEn), .oldestAddress(OLDEST),
		.machineState(STATE), .mcStatusClear(mcClear),
		.loadInLastStage(inLast), .lastStageBusy(busy), .loadHold(loadHold),
		.loadDone(loadDone), .loadHit(loadHit), .loadData(loadData),
		.dbgFault(dbgFault), .dbgDone(dbgDone), .dbgWord(dbgWord),
		.debugTagHigh(tagHigh), .debugTagLow(tagLow),
		.busWrValid(busWrValid), .busWrAddr(busWrAddr),
		.busWrData(busWrData), .busWrParityErr(busWrParityErr),
		.mcTake(mcTake), .mcSavedAddress(mcAddr), .mcSavedState(mcState),
		.mcStatus(mcStatus));
	dcp_core_model core (.clock(clock), .arst_n(arst_n),
		.loadIssued(loadIssued), .otherStall(otherStall),
		.loadDone(loadDone), .loadInLastStage(inLast),
		.lastStageBusy(busy), .busWrValid(busWrValid),
		.busWrAddr(busWrAddr), .busWrData(busWrData),
		.busWrParityErr(busWrParityErr), .wrCount(wrCount),
		.wrAddr(wrAddr), .wrWord(wrWord), .wrErr(wrErr));

	// ------------------------------------------------------------------
	// Clock, timeout and helpers
	// ------------------------------------------------------------------
	initial begin
		clock = 1'h0;
		forever #2.5 clock = ~clock;
	end
	// Cut a hang short
	always @(posedge clock) begin
		cycles <= cycles + 1;
		if (cycles == 3000) begin
			bad_count++;
			give_verdict();
		end
	end
	task automatic give_verdict;
		if (bad_count == 0 && samples_checked > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	task automatic check(string name, logic [35:0] exp, logic [35:0] got);
		samples_checked++;
		if (got !== exp) begin
			bad_count++;
			$display("ERROR %s expected %h seen %h", name, exp, got);
		end
	endtask
	// One request, then watch the result window for pulses
	task automatic issue(dcp_pkg::dcp_op_t op, logic [35:0] a, logic [1:0] w,
		logic priv);
		@(posedge clock);
		opValid <= 1'h1;
		opCode <= op;
		opRealAddr <= a;
		opWay <= w;
		opPrivileged <= priv;
		@(posedge clock);
		opValid <= 1'h0;
		{sawLoad, sawDbg, sawFault, sawMc, sawHold} = 5'h00;
		repeat (4) begin
			@(negedge clock);
			sawLoad = sawLoad | (loadDone & loadHit);
			sawDbg = sawDbg | dbgDone;
			sawFault = sawFault | dbgFault;
			sawMc = sawMc | mcTake;
			sawHold = sawHold | loadHold;
		end
	endtask
	task automatic clearMc;
		@(posedge clock);
		mcClear <= 1'h1;
		@(posedge clock);
		mcClear <= 1'h0;
	endtask
	function automatic logic [255:0] mkLine(int b);
		for (int k = 0; k < 8; k++) mkLine[k*32 +: 32] = (b << 24) + k;
	endfunction
	// Low debug tag as it should read: parity fields, dirty, user
	function automatic logic [31:0] expLow(logic [35:0] a, logic [3:0] u,
		logic [3:0] d, logic p);
		logic [27:0] t;
		t = a[35:8];
		if (!p) return {24'h00_0000, d, u};
		return {13'h0000, ^u, ^(t & 28'hAAAAAAA), ^(t & 28'h5555555),
			4'h0, d, d, u};
	endfunction

	// ------------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------------
	initial begin
		{arst_n, opValid, opPrivileged, pre, stallEn, mcEn, mcClear} = 7'h00;
		{otherStall, opWay, storeData, byteEn, fillUser} = 43'h000_0000_0000;
		opCode = dcp_pkg::OP_LOAD;
		opRealAddr = 36'h0_0000_0000;
		fillData = 256'h0;
		repeat (10) @(posedge clock);
		arst_n <= 1'h1;
		check("tag high", dcp_pkg::DBG_RESET, tagHigh);
		check("tag low", dcp_pkg::DBG_RESET, tagLow);
		check("status", 3'h0, mcStatus);
		// Fill, load back and debug-read each row's line
		foreach (rows[i]) begin
			@(posedge clock);
			fillData <= mkLine(i);
			fillUser <= rows[i].u;
			pre <= rows[i].p;
			issue(dcp_pkg::OP_FILL, rows[i].a, rows[i].w, 1'h1);
			issue(dcp_pkg::OP_LOAD, rows[i].a, rows[i].w, 1'h1);
			check("load hit", 2'h3, {sawLoad, loadHit});
			check("load data", (i << 24) + rows[i].a[4:2], loadData);
			issue(dcp_pkg::OP_DREAD, rows[i].a, rows[i].w, 1'h1);
			@(posedge clock);
			check("dbg done", 1'h1, sawDbg);
			check("dbg word", (i << 24) + rows[i].a[4:2], dbgWord);
			check("tag high", rows[i].h, tagHigh);
			check("tag low", expLow(rows[i].a, rows[i].u, 4'h0, rows[i].p),
				tagLow);
			check("dbg mc", 1'h0, sawMc);
		end
		issue(dcp_pkg::OP_DREAD, rows[0].a, 2'h0, 1'h0);
		check("refused", 2'h2, {sawFault, sawDbg});
		// Store marks doubleword 2 dirty, cast-out writes the line out
		@(posedge clock);
		storeData <= 32'hCAFE_F00D;
		byteEn <= 4'hF;
		pre <= 1'h1;
		issue(dcp_pkg::OP_STORE, rows[0].a, 2'h0, 1'h1);
		issue(dcp_pkg::OP_LOAD, rows[0].a, 2'h0, 1'h1);
		check("store data", 32'hCAFE_F00D, loadData);
		issue(dcp_pkg::OP_DREAD, rows[0].a, 2'h0, 1'h1);
		check("dirty", expLow(rows[0].a, 4'hA, 4'h2, 1'h1), tagLow);
		issue(dcp_pkg::OP_CASTOUT, rows[0].a, 2'h0, 1'h1);
		check("bus count", 8'h01, wrCount);
		check("bus addr", {rows[0].a[35:5], 5'h00}, wrAddr);
		check("bus err", 33'h0, {wrWord, wrErr});
		// Second copy of a line in another way trips multi-hit
		@(posedge clock);
		fillData <= mkLine(1);
		mcEn <= 1'h1;
		issue(dcp_pkg::OP_FILL, rows[1].a, 2'h1, 1'h1);
		issue(dcp_pkg::OP_LOAD, rows[1].a, 2'h0, 1'h1);
		check("mc take", 1'h1, sawMc);
		check("mc status", 3'h3, mcStatus);
		check("mc addr", OLDEST, mcAddr);
		check("mc state", STATE, mcState);
		clearMc();
		issue(dcp_pkg::OP_DREAD, rows[1].a, 2'h3, 1'h1);
		check("dread quiet", 4'h0, {sawMc, mcStatus});
		foreach (lookOps[k]) begin
			clearMc();
			issue(lookOps[k], rows[1].a, 2'h0, 1'h1);
			check("lookup status", 3'h3, mcStatus);
		end
		@(posedge clock);
		mcEn <= 1'h0;
		clearMc();
		issue(dcp_pkg::OP_LOAD, rows[1].a, 2'h0, 1'h1);
		check("mc gated", 4'h3, {sawMc, mcStatus});
		// Recovery stall holds a load once, never on top of another stall
		@(posedge clock);
		stallEn <= 1'h1;
		issue(dcp_pkg::OP_LOAD, rows[2].a, rows[2].w, 1'h1);
		check("hold", 1'h1, sawHold);
		@(posedge clock);
		otherStall <= 1'h1;
		issue(dcp_pkg::OP_LOAD, rows[2].a, rows[2].w, 1'h1);
		check("no extra hold", 1'h0, sawHold);
		// Clock enable low freezes the sticky status against a clear
		@(posedge clock);
		ce <= 1'h0;
		clearMc();
		check("frozen", 3'h3, mcStatus);
		ce <= 1'h1;
		give_verdict();
	end
endmodule
